// ==== hdl/wlsw_pkg.sv ====
// Shared constants and types for the wake level and switch fault status bank
package wlsw_pkg;
  // Register indices; byte address is four times the index
  localparam int WLSW_IDX_W = 7;
  localparam logic [6:0] IDX_WAKE_LVL = 7'h48;
  localparam logic [6:0] IDX_OVERLOAD = 7'h54;
  localparam logic [6:0] IDX_OPEN_LOAD = 7'h55;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h60;
  localparam logic [6:0] IDX_IRQ_STAT = 7'h61;
  localparam logic [6:0] IDX_CTRL = 7'h62;
  localparam logic [6:0] IDX_IDENT = 7'h7E;
  localparam int ADR_LSB = 2;
  localparam int ADR_MSB = 8;
  // Wake level register layout
  localparam int BIT_DEV_STRAP = 7;
  localparam int BIT_PULLUP = 6;
  localparam int BIT_GPIO_B = 5;
  localparam int BIT_GPIO_A = 4;
  localparam int BIT_WAKE_RSVD = 3;
  localparam int WAKE_LSB = 0;
  localparam int WAKE_N = 3;
  // Switch flag width and family/product field positions
  localparam int FLAG_W = 4;
  localparam int FAM_LSB = 4;
  localparam int PRODUCT_CODE_LSB = 0;
  // Control register layout
  localparam int CTRL_GPA_LSB = 0;
  localparam int CTRL_GPB_LSB = 2;
  localparam int CTRL_CYC_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Interrupt status and mask layout
  localparam int IRQ_OVERLOAD = 0;
  localparam int IRQ_OPEN_LOAD = 1;
  localparam int IRQ_W = 2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Device operating mode, one-hot
  typedef enum logic [3:0] {
    WLSW_NORMAL = 4'b0001,
    WLSW_STOP = 4'b0010,
    WLSW_SLEEP = 4'b0100,
    WLSW_FAIL_SAFE = 4'b1000
  } wlsw_op_mode_t;

  // Function of a general-purpose pin
  typedef enum logic [1:0] {
    WLSW_GP_OFF = 2'b00,
    WLSW_GP_WAKE = 2'b01,
    WLSW_GP_LOW_SIDE = 2'b10,
    WLSW_GP_HIGH_SIDE = 2'b11
  } wlsw_gp_func_t;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } wlsw_wb_req_t;

  // Pin levels seen by the bank
  typedef struct packed {
    logic fail_output_test_pin;
    logic pullup_config_strap;
    logic gpio_b;
    logic gpio_a;
    logic [2:0] wake;
  } wlsw_pins_t;
endpackage : wlsw_pkg

// ==== hdl/wlsw_rc_flags.sv ====
// Read-to-clear sticky flag bank
`timescale 1ns/1ps
module wlsw_rc_flags
  import wlsw_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clear_all,
  input wire logic [W-1:0] set_i,
  input wire logic rd_clear,
  output logic [W-1:0] flags
);
  // One sticky bit per source; a set in the rd_clear cycle wins, but clear_all beats a set
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge mclk) begin
      if (reset || clear_all) begin
        flags[i] <= 1'b0;
      end else if (set_i[i]) begin
        flags[i] <= 1'b1;
      end else if (rd_clear) begin
        flags[i] <= 1'b0;
      end
    end
  end
endmodule : wlsw_rc_flags

// ==== hdl/wlsw_status_bank.sv ====
// Wake level and high-side switch fault status bank on a Wishbone slave
//
// Notes on behaviour
// - Bit 7 shows operating mode strap
// - Bit 6 shows interrupt pin pull-up strap
// - Bits 5,4 show general pin levels
// - Reserved bits always read zero
// - Pin levels refresh in Normal and Stop
// - Cyclic wake inputs hold last sampled level
// - General pins never cyclically sampled
// - Level shown even when used as switch
// - Overload flags per switch, read-to-clear
// - Open-load flags per switch, read-to-clear
// - Overload may falsely set at low supply
// - Identity register: family high, product low
// - Product code is a per-variant parameter
// - Reset forces general pin level bits zero
`timescale 1ns/1ps
module wlsw_status_bank
  import wlsw_pkg::*;
#(
  parameter logic [3:0] FAMILY_CODE = 4'hA, // Arbitrary value
  parameter logic [3:0] PRODUCT_CODE = 4'h6 // Arbitrary value, set per variant
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic soft_reset_pulse,
  input wire logic restart_pulse,
  input wire wlsw_op_mode_t op_mode,
  input wire wlsw_pins_t pins,
  input wire logic wake_sample_pulse,
  input wire logic [FLAG_W-1:0] overload_event,
  input wire logic [FLAG_W-1:0] open_load_event,
  input wire wlsw_wb_req_t wb_req,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Address match on a register index
  function automatic logic idx_hit(input logic [WLSW_IDX_W-1:0] idx,
                                   input logic [WLSW_IDX_W-1:0] target);
    idx_hit = (idx == target);
  endfunction : idx_hit

  // A general pin is refreshed only when awake and given a function
  function automatic logic gp_refresh(input wlsw_op_mode_t mode,
                                      input wlsw_gp_func_t func);
    logic awake;
    awake = 1'b0;
    unique case (mode)
      WLSW_NORMAL, WLSW_STOP: awake = 1'b1;
      WLSW_SLEEP, WLSW_FAIL_SAFE: awake = 1'b0;
      default: awake = 1'b0; // Illegal one-hot code freezes the level
    endcase
    gp_refresh = awake && (func != WLSW_GP_OFF);
  endfunction : gp_refresh

  //////////////////////////////////////////////////////////////////////////////
  // Bus request decode

  logic ack_reg;
  logic [31:0] dat_reg;
  logic irq_reg;
  logic req;
  logic rd;
  logic wr;
  logic [WLSW_IDX_W-1:0] idx;

  // A request is taken once; the acking cycle blocks a second take
  assign req = wb_req.cyc && wb_req.stb && !ack_reg;
  assign rd = req && !wb_req.we;
  assign wr = req && wb_req.we && wb_req.sel[0];
  assign idx = wb_req.adr[ADR_MSB:ADR_LSB];

  //////////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [7:0] ctrl_reg;
  logic [IRQ_W-1:0] mask_reg;
  wlsw_gp_func_t gpa_func;
  wlsw_gp_func_t gpb_func;
  logic [WAKE_N-1:0] cyclic_en;

  // Control and mask; soft reset returns them to defaults
  always_ff @(posedge mclk) begin
    if (reset || soft_reset_pulse) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= '0;
    end else if (wr && idx_hit(idx, IDX_CTRL)) begin
      ctrl_reg <= wb_req.dat[7:0];
    end else if (wr && idx_hit(idx, IDX_IRQ_MASK)) begin
      mask_reg <= wb_req.dat[IRQ_W-1:0];
    end
  end

  assign gpa_func = wlsw_gp_func_t'(ctrl_reg[CTRL_GPA_LSB +: 2]);
  assign gpb_func = wlsw_gp_func_t'(ctrl_reg[CTRL_GPB_LSB +: 2]);
  assign cyclic_en = ctrl_reg[CTRL_CYC_LSB +: WAKE_N];

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture

  logic strap_arm_reg;
  logic dev_strap_reg;
  logic pullup_strap_reg;

  // Straps are caught in the cycle after reset release, soft reset or restart
  always_ff @(posedge mclk) begin
    if (reset) begin
      strap_arm_reg <= 1'b1;
    end else begin
      strap_arm_reg <= soft_reset_pulse || restart_pulse;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dev_strap_reg <= 1'b0;
      pullup_strap_reg <= 1'b0;
    end else if (strap_arm_reg) begin
      dev_strap_reg <= pins.fail_output_test_pin;
      pullup_strap_reg <= pins.pullup_config_strap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wake input levels

  logic [WAKE_N-1:0] wake_lvl_reg;
  logic [WAKE_N-1:0] wake_lvl_next;

  // Tracking inputs follow the pin; cyclic ones only move on a sample
  for (genvar i = 0; i < WAKE_N; i++) begin : g_wake
    assign wake_lvl_next[i] = (!cyclic_en[i] || wake_sample_pulse) ?
                              pins.wake[i] : wake_lvl_reg[i];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wake_lvl_reg <= '0;
    end else begin
      wake_lvl_reg <= wake_lvl_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // General pin levels

  logic gpa_lvl_reg;
  logic gpb_lvl_reg;

  // No sample pulse reaches these bits; they refresh on mode and function only
  always_ff @(posedge mclk) begin
    if (reset || soft_reset_pulse) begin
      gpa_lvl_reg <= 1'b0;
      gpb_lvl_reg <= 1'b0;
    end else begin
      if (gp_refresh(op_mode, gpa_func)) begin
        gpa_lvl_reg <= pins.gpio_a;
      end
      if (gp_refresh(op_mode, gpb_func)) begin
        gpb_lvl_reg <= pins.gpio_b;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault and interrupt flags

  logic [FLAG_W-1:0] ovl_flags;
  logic [FLAG_W-1:0] ol_flags;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_set;
  logic flag_clear;

  // Only power-on and soft reset wipe the flags; restart leaves them
  assign flag_clear = soft_reset_pulse;
  assign irq_set[IRQ_OVERLOAD] = |overload_event;
  assign irq_set[IRQ_OPEN_LOAD] = |open_load_event;

  // Overload events pass unfiltered, so low-supply glitches do get latched
  wlsw_rc_flags #(.W(FLAG_W)) u_overload (
    .mclk(mclk),
    .reset(reset),
    .clear_all(flag_clear),
    .set_i(overload_event),
    .rd_clear(rd && idx_hit(idx, IDX_OVERLOAD)),
    .flags(ovl_flags)
  );

  wlsw_rc_flags #(.W(FLAG_W)) u_open_load (
    .mclk(mclk),
    .reset(reset),
    .clear_all(flag_clear),
    .set_i(open_load_event),
    .rd_clear(rd && idx_hit(idx, IDX_OPEN_LOAD)),
    .flags(ol_flags)
  );

  wlsw_rc_flags #(.W(IRQ_W)) u_irq (
    .mclk(mclk),
    .reset(reset),
    .clear_all(flag_clear),
    .set_i(irq_set),
    .rd_clear(rd && idx_hit(idx, IDX_IRQ_STAT)),
    .flags(irq_stat)
  );

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat & mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux and answer

  logic [7:0] rdata;

  // Unused and reserved bits read zero; unmapped indices read zero
  always_comb begin
    rdata = BYTE_ZERO;
    if (idx_hit(idx, IDX_WAKE_LVL)) begin
      rdata[BIT_DEV_STRAP] = dev_strap_reg;
      rdata[BIT_PULLUP] = pullup_strap_reg;
      rdata[BIT_GPIO_B] = gpb_lvl_reg;
      rdata[BIT_GPIO_A] = gpa_lvl_reg;
      rdata[WAKE_LSB +: WAKE_N] = wake_lvl_reg;
    end else if (idx_hit(idx, IDX_OVERLOAD)) begin
      rdata[FLAG_W-1:0] = ovl_flags;
    end else if (idx_hit(idx, IDX_OPEN_LOAD)) begin
      rdata[FLAG_W-1:0] = ol_flags;
    end else if (idx_hit(idx, IDX_IDENT)) begin
      rdata[FAM_LSB +: 4] = FAMILY_CODE;
      rdata[PRODUCT_CODE_LSB +: 4] = PRODUCT_CODE;
    end else if (idx_hit(idx, IDX_IRQ_MASK)) begin
      rdata[IRQ_W-1:0] = mask_reg;
    end else if (idx_hit(idx, IDX_IRQ_STAT)) begin
      rdata[IRQ_W-1:0] = irq_stat;
    end else if (idx_hit(idx, IDX_CTRL)) begin
      rdata = ctrl_reg;
    end
  end

  // Ack one cycle after the take; data sampled with the clearing edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      dat_reg <= WORD_ZERO;
    end else begin
      ack_reg <= req;
      dat_reg <= rd ? {24'h00_0000, rdata} : WORD_ZERO;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_rd(logic [6:0] r);
    rd && idx_hit(idx, r);
  endsequence

  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_answer;
    req |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("Ack not a single pulse");

  property p_dev_strap;
    s_rd(IDX_WAKE_LVL) |=> wb_dat_o[BIT_DEV_STRAP] == $past(dev_strap_reg);
  endproperty
  a_dev_strap: assert property (p_dev_strap) else $error("Strap bit wrong");

  property p_reserved;
    s_rd(IDX_WAKE_LVL) |=> !wb_dat_o[BIT_WAKE_RSVD] && wb_dat_o[31:8] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set");

  property p_ident;
    s_rd(IDX_IDENT) |=> wb_dat_o[7:0] == {FAMILY_CODE, PRODUCT_CODE};
  endproperty
  a_ident: assert property (p_ident) else $error("Identity wrong");

  property p_ovl_clear;
    rd && idx_hit(idx, IDX_OVERLOAD) && overload_event == '0 |=> ovl_flags == '0;
  endproperty
  a_ovl_clear: assert property (p_ovl_clear) else $error("Overload not cleared");

  property p_ol_clear;
    rd && idx_hit(idx, IDX_OPEN_LOAD) && open_load_event == '0 |=> ol_flags == '0;
  endproperty
  a_ol_clear: assert property (p_ol_clear) else $error("Open load not cleared");

  property p_set_wins;
    rd && idx_hit(idx, IDX_OVERLOAD) && overload_event[0] && !soft_reset_pulse
      |=> ovl_flags[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Event lost on read");

  property p_soft_clear;
    soft_reset_pulse |=> ovl_flags == '0 && ol_flags == '0 && !gpa_lvl_reg && !gpb_lvl_reg;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("Soft reset left state");

  property p_restart_keep;
    restart_pulse && !soft_reset_pulse && overload_event == '0 && !(rd && idx_hit(idx, IDX_OVERLOAD))
      |=> $stable(ovl_flags);
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("Restart lost flags");

  property p_cyclic_hold;
    cyclic_en[0] && !wake_sample_pulse |=> $stable(wake_lvl_reg[0]);
  endproperty
  a_cyclic_hold: assert property (p_cyclic_hold) else $error("Cyclic level moved");

  property p_gpio_track;
    op_mode == WLSW_NORMAL && gpa_func != WLSW_GP_OFF && !soft_reset_pulse
      |=> gpa_lvl_reg == $past(pins.gpio_a);
  endproperty
  a_gpio_track: assert property (p_gpio_track) else $error("Pin level stale");

  property p_gpio_freeze;
    op_mode == WLSW_SLEEP && !soft_reset_pulse |=> $stable(gpa_lvl_reg) && $stable(gpb_lvl_reg);
  endproperty
  a_gpio_freeze: assert property (p_gpio_freeze) else $error("Pin level sampled");

  property p_irq;
    |(irq_stat & mask_reg) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt missing");

endmodule : wlsw_status_bank

// ==== verification/wlsw_host_model.sv ====
// Host side model: a classic Wishbone master that reads and writes the bank
`timescale 1ns/1ps
module wlsw_host_model
  import wlsw_pkg::*;
(
  input wire logic mclk,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  output wlsw_wb_req_t wb_req
);
  //////////////////////////////////////////////////////////////////
  // Bus idle until the first cycle
  initial wb_req = '0;

  // One full cycle; request held until ack is sampled, released at that edge
  task automatic bus_cycle(input logic we, input logic [6:0] idx, input logic [7:0] wdat,
                           output logic [31:0] rdat);
    @(posedge mclk);
    wb_req <= '{1'b1, 1'b1, we, 4'hF, {23'h0, idx, 2'b00}, {24'h0, wdat}};
    // No assumed latency; a missing ack is left to the bench watchdog
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_req <= '0;
  endtask : bus_cycle
endmodule : wlsw_host_model

// ==== verification/wlsw_status_bank_tb_top.sv ====
// Self-checking bench for the wake level and switch fault status bank
`timescale 1ns/1ps
module wlsw_status_bank_tb_top
  import wlsw_pkg::*;
;
  localparam logic [3:0] FAM_T = 4'hC; // Arbitrary value
  localparam logic [3:0] PRODUCT_CODE_T = 4'h7; // Arbitrary value
  logic mclk = 1'b0;
  logic reset, soft_rst, restart, wsp, ack, irq;
  wlsw_op_mode_t op_mode;
  wlsw_pins_t pins;
  logic [3:0] ovl, opl;
  wlsw_wb_req_t wb_req;
  logic [31:0] dat, rd;
  int num_errors = 0;
  int samples_checked = 0;

  //////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 mclk = ~mclk;

  wlsw_host_model host_u (.mclk(mclk), .wb_ack_o(ack), .wb_dat_o(dat), .wb_req(wb_req));

  wlsw_status_bank #(.FAMILY_CODE(FAM_T), .PRODUCT_CODE(PRODUCT_CODE_T)) dut_u (
    .mclk(mclk), .reset(reset), .soft_reset_pulse(soft_rst), .restart_pulse(restart),
    .op_mode(op_mode), .pins(pins), .wake_sample_pulse(wsp), .overload_event(ovl),
    .open_load_event(opl), .wb_req(wb_req), .wb_ack_o(ack), .wb_dat_o(dat), .irq_o(irq));

  //////////////////////////////////////////////////////////////////
  // Shared compare, bus and event helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [6:0] idx, input logic [31:0] exp);
    host_u.bus_cycle(1'b0, idx, 8'h00, rd);
    check($sformatf("reg %h", idx), rd, exp);
  endtask : rd_chk

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    host_u.bus_cycle(1'b1, idx, d, rd);
  endtask : wr

  // One-cycle detection pulses, then time for the interrupt to settle
  task automatic ev(input logic [3:0] o, input logic [3:0] l);
    @(posedge mclk);
    ovl <= o;
    opl <= l;
    @(posedge mclk);
    ovl <= 4'h0;
    opl <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask : ev

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  //////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_levels();
    rd_chk(IDX_WAKE_LVL, 32'h0000_00C5);
    rd_chk(7'h10, 32'h0000_0000);
    $display("t_levels done");
  endtask : t_levels

  // Switch functions still show the level; sleep freezes it
  task automatic t_gpio();
    wr(IDX_CTRL, 8'h0B);
    rd_chk(IDX_WAKE_LVL, 32'h0000_00F5);
    @(posedge mclk);
    op_mode <= WLSW_SLEEP;
    pins.gpio_a <= 1'b0;
    rd_chk(IDX_WAKE_LVL, 32'h0000_00F5);
    @(posedge mclk);
    op_mode <= WLSW_STOP;
    rd_chk(IDX_WAKE_LVL, 32'h0000_00E5);
    $display("t_gpio done");
  endtask : t_gpio

  task automatic t_cyclic();
    wr(IDX_CTRL, 8'h1B);
    @(posedge mclk);
    pins.wake <= 3'b100;
    rd_chk(IDX_WAKE_LVL, 32'h0000_00E5);
    @(posedge mclk);
    wsp <= 1'b1;
    @(posedge mclk);
    wsp <= 1'b0;
    rd_chk(IDX_WAKE_LVL, 32'h0000_00E4);
    $display("t_cyclic done");
  endtask : t_cyclic

  task automatic t_flags();
    wr(IDX_IRQ_MASK, 8'h03);
    ev(4'h9, 4'h6);
    check("irq_o", {31'h0, irq}, 32'h0000_0001);
    rd_chk(IDX_OVERLOAD, 32'h0000_0009);
    rd_chk(IDX_OVERLOAD, 32'h0000_0000);
    rd_chk(IDX_OPEN_LOAD, 32'h0000_0006);
    rd_chk(IDX_OPEN_LOAD, 32'h0000_0000);
    rd_chk(IDX_IRQ_STAT, 32'h0000_0003);
    repeat (3) @(posedge mclk);
    check("irq_o", {31'h0, irq}, 32'h0000_0000);
    // Masked event must stay silent but still be recorded
    wr(IDX_IRQ_MASK, 8'h00);
    ev(4'h1, 4'h0);
    check("irq_o", {31'h0, irq}, 32'h0000_0000);
    rd_chk(IDX_IRQ_STAT, 32'h0000_0001);
    rd_chk(IDX_OVERLOAD, 32'h0000_0001);
    $display("t_flags done");
  endtask : t_flags

  // Detection seen only at the clearing edge: read shows 0, flag must survive
  task automatic t_set_wins();
    fork
      host_u.bus_cycle(1'b0, IDX_OVERLOAD, 8'h00, rd);
      begin
        @(posedge mclk);
        ovl <= 4'h1;
        @(posedge mclk);
        ovl <= 4'h0;
      end
    join
    check("overload", rd, 32'h0000_0000);
    rd_chk(IDX_OVERLOAD, 32'h0000_0001);
    rd_chk(IDX_OVERLOAD, 32'h0000_0000);
    $display("t_set_wins done");
  endtask : t_set_wins

  task automatic t_resets();
    ev(4'h2, 4'h8);
    @(posedge mclk);
    pins.fail_output_test_pin <= 1'b0;
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
    rd_chk(IDX_OVERLOAD, 32'h0000_0002);
    rd_chk(IDX_WAKE_LVL, 32'h0000_0064);
    @(posedge mclk);
    soft_rst <= 1'b1;
    @(posedge mclk);
    soft_rst <= 1'b0;
    rd_chk(IDX_OPEN_LOAD, 32'h0000_0000);
    rd_chk(IDX_WAKE_LVL, 32'h0000_0044);
    rd_chk(IDX_CTRL, 32'h0000_0000);
    $display("t_resets done");
  endtask : t_resets

  task automatic t_ident();
    wr(IDX_IDENT, 8'h00);
    rd_chk(IDX_IDENT, {24'h0, FAM_T, PRODUCT_CODE_T});
    $display("t_ident done");
  endtask : t_ident

  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    soft_rst = 1'b0;
    restart = 1'b0;
    wsp = 1'b0;
    ovl = 4'h0;
    opl = 4'h0;
    op_mode = WLSW_NORMAL;
    pins = '{1'b1, 1'b1, 1'b1, 1'b1, 3'b101};
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    t_levels();
    t_gpio();
    t_cyclic();
    t_flags();
    t_set_wins();
    t_resets();
    t_ident();
    wrap_up();
  end

  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #200us;
    num_errors++;
    wrap_up();
  end
endmodule : wlsw_status_bank_tb_top
